// *** hdl/pmf_pkg.sv ***
// pmf_pkg: shared constants and types of the measurement sequencer
// assumes: 32-bit apb register map, one aligned word per register
package pmf_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_PSR_CFG = 8'h00; // pressure precision and rate
   localparam logic [7:0] ADDR_TMP_CFG = 8'h04; // temperature precision and rate
   localparam logic [7:0] ADDR_MEAS_CFG = 8'h08; // mode control and status
   localparam logic [7:0] ADDR_CFG = 8'h0c; // fifo and interrupt setup
   localparam logic [7:0] ADDR_RES_P = 8'h10; // pressure result or fifo head
   localparam logic [7:0] ADDR_RES_T = 8'h14; // temperature result
   localparam logic [7:0] ADDR_FIFO_STATUS = 8'h18; // fifo status
   // precision/rate register fields
   localparam int PREC_LSB = 0; // precision [2:0]
   localparam int RATE_LSB = 4; // rate [6:4]
   // measurement config fields
   localparam int MODE_LSB = 0; // mode control [2:0]
   localparam int CONT_BIT = 6; // continuous-mode flag
   localparam int BUSY_BIT = 7; // conversion running
   // config fields
   localparam int INTSEL_LSB = 0; // interrupt select [3:0]
   localparam int FIFO_EN_BIT = 4; // fifo enable
   localparam int STOP_FULL_BIT = 5; // stop on full
   localparam int WM_LSB = 8; // watermark [13:8]
   // fifo status fields
   localparam int FS_EMPTY_BIT = 0; // fifo empty
   localparam int FS_FULL_BIT = 1; // fifo full
   localparam int FS_FULLWM_BIT = 2; // full or watermark reached
   localparam int FS_CNT_LSB = 8; // entry count [13:8]
   // mode control codes
   localparam logic [2:0] MODE_STANDBY = 3'h0; // no conversions
   localparam logic [2:0] MODE_CMD_P = 3'h1; // single pressure
   localparam logic [2:0] MODE_CMD_T = 3'h2; // single temperature
   localparam logic [2:0] MODE_CMD_PT = 3'h3; // one of each
   localparam logic [2:0] MODE_BG_P = 3'h5; // continuous pressure
   localparam logic [2:0] MODE_BG_T = 3'h6; // continuous temperature
   localparam logic [2:0] MODE_BG_PT = 3'h7; // continuous both
   // interrupt source codes
   localparam logic [3:0] INT_NONE = 4'h0; // no interrupt
   localparam logic [3:0] INT_NEW = 4'h02; // new result available
   localparam logic [3:0] INT_WM = 4'h04; // watermark reached
   localparam logic [3:0] INT_FULL = 4'h08; // fifo full
   // data constants
   localparam int FIFO_DEPTH = 32; // fifo entries
   localparam logic [23:0] EMPTY_READ = 24'h800000; // fifo read when empty
   localparam logic [31:0] CFG_RST = 32'h0000_0000; // config reset value
   // timing: rate code r means 2**r conversions per period
   localparam int CLK_HZ = 100_000_000; // ref_clk rate
   localparam int RATE_PERIOD_MS = 1000; // base period in ms
   localparam int RATE_PERIOD_CYC = CLK_HZ / 1000 * RATE_PERIOD_MS; // base period cycles
   // one stored conversion result
   typedef struct packed {
      logic isPressure; // type of result
      logic [23:0] value; // result, lsb holds the type tag
   } pmf_result_s;
   // request to the converter
   typedef struct packed {
      logic start; // one-cycle start pulse
      logic isPressure; // pressure or temperature
      logic [2:0] precision; // oversampling setting
   } pmf_conv_req_s;
endpackage : pmf_pkg

// *** hdl/pmf_period_timer.sv ***
// pmf_period_timer: repeating tick whose interval follows a rate code
// assumes: run low holds the timer so the first tick comes right after run rises
`timescale 1ns/1ns
module pmf_period_timer #(
   parameter int BASE_CYC = 100_000_000, // interval for rate code 0
   parameter int CW = 27 // counter width
) (
   input wire logic ref_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic run, // timer enabled
   input wire logic [2:0] rate, // 2**rate ticks per base interval
   output logic tick // one-cycle pulse per interval
);
   initial begin
      if (BASE_CYC < 256 || BASE_CYC >= (2 ** CW)) $error("pmf_period_timer: bad BASE_CYC");
   end
   logic [CW-1:0] count; // cycles left to next tick
   logic [CW-1:0] reload; // interval for the current rate
   assign reload = CW'(BASE_CYC) >> rate;
   // count down, reload at zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
         tick <= 1'b0;
      end else if (!run) begin
         count <= '0; // first tick at once when started
         tick <= 1'b0;
      end else if (count == '0) begin
         count <= reload - CW'(1);
         tick <= 1'b1;
      end else begin
         count <= count - CW'(1);
         tick <= 1'b0;
      end
   end
endmodule : pmf_period_timer

// *** hdl/pmf_fifo.sv ***
// pmf_fifo: result fifo with streaming or stop-on-full behaviour
// assumes: pop is only asserted by a host read, push by a finished conversion
`timescale 1ns/1ns
module pmf_fifo #(
   parameter int DEPTH = 32, // entries, power of two
   parameter int W = 25 // entry width
) (
   input wire logic ref_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic push, // store an entry
   input wire logic [W-1:0] pushData, // entry to store
   input wire logic pop, // drop the head entry
   input wire logic stopOnFull, // 1: refuse when full, 0: overwrite oldest
   output logic [W-1:0] head, // oldest entry
   output logic [$clog2(DEPTH):0] count // entries held
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (2 ** AW) != DEPTH) $error("pmf_fifo: DEPTH must be a power of two");
   end
   logic [W-1:0] mem [DEPTH]; // entry storage
   logic [AW-1:0] wrPtr; // next free slot
   logic [AW-1:0] rdPtr; // oldest entry
   logic full; // holds DEPTH entries
   logic doPop; // pop of a real entry
   logic doPush; // entry accepted
   logic dropOld; // streaming overwrite of oldest
   assign full = (count == (AW+1)'(DEPTH));
   assign doPop = pop && (count != '0);
   assign doPush = push && !(full && stopOnFull && !doPop);
   assign dropOld = doPush && full && !doPop;
   assign head = mem[rdPtr];
   // storage write
   always_ff @(posedge ref_clk) begin
      if (doPush) begin
         mem[wrPtr] <= pushData;
      end
   end
   // pointers and count
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doPush) begin
            wrPtr <= wrPtr + AW'(1);
         end
         if (doPop || dropOld) begin
            rdPtr <= rdPtr + AW'(1);
         end
         if (doPush && !doPop && !dropOld) begin
            count <= count + (AW+1)'(1);
         end else if (doPop && !doPush) begin
            count <= count - (AW+1)'(1);
         end
      end
   end
endmodule : pmf_fifo

// *** hdl/pmf_top.sv ***
// pmf_top: mode sequencing, result storage and fifo of a pressure sensor readout
// assumes: apb master on the host side; an external converter answers convStart
// with convDone and convData some cycles later, one conversion at a time
//
// Notes on behaviour
// - reset enters standby, no conversions run
// - standby keeps every register reachable
// - command mode: one P, T or both
// - command result stored, then back to standby
// - fifo accumulates single-shot results too
// - background repeats conversions at configured rate
// - background temperature follows pressure immediately
// - result to registers, or fifo when enabled
// - fifo holds 32 mixed results
// - streaming full drops oldest entry
// - stop-on-full refuses new entries
// - one interrupt source selectable, or none
// - pressure and temperature settings kept separate
// - result lsb tags pressure 1, temperature 0
// - empty flag set; empty read gives 0x800000
// - watermark interrupt when count equals level
// - cleared mode finishes conversion, then standby
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module pmf_top #(
   parameter int RATE_BASE_CYC = pmf_pkg::RATE_PERIOD_CYC // base interval, shorten in sim
) (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rstn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output pmf_pkg::pmf_conv_req_s convReq, // converter request
   input wire logic convDone, // converter finished, one cycle
   input wire logic [23:0] convData, // converter result with convDone
   output logic intOut // interrupt, active high level
);
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN_P,
      ST_RUN_T
   } pmf_state_e;

   pmf_state_e state; // sequencer state
   logic [6:0] psrCfg; // pressure precision and rate
   logic [6:0] tmpCfg; // temperature precision and rate
   logic [2:0] modeCtl; // mode control field
   logic contFlag; // continuous-mode flag
   logic [13:0] cfg; // interrupt select, fifo setup, watermark
   logic [23:0] resP; // last pressure result
   logic [23:0] resT; // last temperature result
   logic newFlag; // unread result present
   logic tPending; // temperature due in background
   logic pTick; // pressure timer tick
   logic tTick; // temperature timer tick
   logic setupRd; // apb setup of a read
   logic accessDone; // apb access completes this edge
   logic wrEn; // write takes effect
   logic rdEn; // read takes effect
   logic popFifo; // host read of fifo head
   logic pushFifo; // finished conversion into fifo
   logic fifoEn; // fifo enabled
   logic [5:0] fifoCount; // fifo entries
   pmf_pkg::pmf_result_s fifoHead; // oldest fifo entry
   pmf_pkg::pmf_result_s newRes; // finished conversion, tagged
   logic isBg; // background mode selected
   logic wantP; // pressure selected
   logic wantT; // temperature selected
   logic fifoFull; // fifo full
   logic fifoEmpty; // fifo empty
   logic wmHit; // count equals watermark
   logic mapped; // address decodes
   logic [31:0] rdMux; // read data for paddr
   logic next_int; // interrupt level

   assign fifoEn = cfg[pmf_pkg::FIFO_EN_BIT];
   assign isBg = modeCtl[2];
   assign wantP = modeCtl[0];
   assign wantT = modeCtl[1];
   assign fifoFull = (fifoCount == 6'(pmf_pkg::FIFO_DEPTH));
   assign fifoEmpty = (fifoCount == 6'h00);
   assign wmHit = (fifoCount == cfg[pmf_pkg::WM_LSB +: 6]) && !fifoEmpty;
   assign accessDone = psel && penable && pready;
   assign wrEn = accessDone && pwrite && !pslverr;
   assign rdEn = accessDone && !pwrite && !pslverr;
   assign setupRd = psel && !penable && !pwrite;
   assign popFifo = rdEn && fifoEn && (paddr == pmf_pkg::ADDR_RES_P);
   // tag the lsb with the result type
   assign newRes.isPressure = (state == ST_RUN_P);
   assign newRes.value = {convData[23:1], state == ST_RUN_P};
   assign pushFifo = convDone && fifoEn && (state != ST_IDLE);

   // address decode and read mux
   always_comb begin
      mapped = 1'b1;
      rdMux = 32'h0000_0000;
      case (paddr)
         pmf_pkg::ADDR_PSR_CFG: rdMux[6:0] = psrCfg;
         pmf_pkg::ADDR_TMP_CFG: rdMux[6:0] = tmpCfg;
         pmf_pkg::ADDR_MEAS_CFG: begin
            rdMux[pmf_pkg::MODE_LSB +: 3] = modeCtl;
            rdMux[pmf_pkg::CONT_BIT] = contFlag;
            rdMux[pmf_pkg::BUSY_BIT] = (state != ST_IDLE);
         end
         pmf_pkg::ADDR_CFG: rdMux[13:0] = cfg;
         pmf_pkg::ADDR_RES_P: begin
            if (!fifoEn) begin
               rdMux[23:0] = resP;
            end else if (fifoEmpty) begin
               rdMux[23:0] = pmf_pkg::EMPTY_READ;
            end else begin
               rdMux[23:0] = fifoHead.value;
            end
         end
         pmf_pkg::ADDR_RES_T: rdMux[23:0] = resT;
         pmf_pkg::ADDR_FIFO_STATUS: begin
            rdMux[pmf_pkg::FS_EMPTY_BIT] = fifoEmpty;
            rdMux[pmf_pkg::FS_FULL_BIT] = fifoFull;
            rdMux[pmf_pkg::FS_FULLWM_BIT] = fifoFull || wmHit;
            rdMux[pmf_pkg::FS_CNT_LSB +: 6] = fifoCount;
         end
         default: mapped = 1'b0; // unmapped: error, zero data
      endcase
   end

   // apb answer: ready one cycle after setup, data captured in setup
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= setupRd ? rdMux : 32'h0000_0000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // precision and rate registers, each pair on its own, and the fifo and interrupt config register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         psrCfg <= 7'h00;
         tmpCfg <= 7'h00;
         cfg <= pmf_pkg::CFG_RST[13:0];
      end else if (wrEn) begin
         if (paddr == pmf_pkg::ADDR_PSR_CFG) begin
            psrCfg <= pwdata[6:0];
         end
         if (paddr == pmf_pkg::ADDR_TMP_CFG) begin
            tmpCfg <= pwdata[6:0];
         end
         if (paddr == pmf_pkg::ADDR_CFG) begin
            cfg <= pwdata[13:0];
         end
      end
   end

   // mode control: host writes; command modes clear themselves when done
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         modeCtl <= pmf_pkg::MODE_STANDBY;
      end else if (wrEn && paddr == pmf_pkg::ADDR_MEAS_CFG) begin
         modeCtl <= pwdata[pmf_pkg::MODE_LSB +: 3];
      end else if (!isBg && convDone && state == ST_RUN_T) begin
         modeCtl <= pmf_pkg::MODE_STANDBY;
      end else if (!isBg && convDone && state == ST_RUN_P && !wantT) begin
         modeCtl <= pmf_pkg::MODE_STANDBY;
      end
   end

   // continuous flag: set in background, cleared once idle outside it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         contFlag <= 1'b0;
      end else if (isBg && modeCtl != pmf_pkg::MODE_STANDBY) begin
         contFlag <= 1'b1;
      end else if (state == ST_IDLE) begin
         contFlag <= 1'b0;
      end
   end

   // background pacing timers, one per measurement type
   pmf_period_timer #(
      .BASE_CYC(RATE_BASE_CYC),
      .CW(27)
   ) uTimerP (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .run(isBg && wantP),
      .rate(psrCfg[pmf_pkg::RATE_LSB +: 3]),
      .tick(pTick)
   );
   pmf_period_timer #(
      .BASE_CYC(RATE_BASE_CYC),
      .CW(27)
   ) uTimerT (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .run(isBg && wantT),
      .rate(tmpCfg[pmf_pkg::RATE_LSB +: 3]),
      .tick(tTick)
   );

   // temperature due flag; a tick that lands with the clear is kept
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tPending <= 1'b0;
      end else if (tTick) begin
         tPending <= 1'b1;
      end else if (!isBg || (convReq.start && !convReq.isPressure)) begin
         tPending <= 1'b0;
      end
   end

   // sequencer: start conversions, wait for completion
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         convReq <= '0;
      end else begin
         convReq.start <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (!isBg && wantP) begin
                  state <= ST_RUN_P;
                  convReq <= '{1'b1, 1'b1, psrCfg[pmf_pkg::PREC_LSB +: 3]};
               end else if (!isBg && wantT) begin
                  state <= ST_RUN_T;
                  convReq <= '{1'b1, 1'b0, tmpCfg[pmf_pkg::PREC_LSB +: 3]};
               end else if (isBg && wantP && pTick) begin
                  state <= ST_RUN_P;
                  convReq <= '{1'b1, 1'b1, psrCfg[pmf_pkg::PREC_LSB +: 3]};
               end else if (isBg && wantT && !wantP && tPending) begin
                  state <= ST_RUN_T;
                  convReq <= '{1'b1, 1'b0, tmpCfg[pmf_pkg::PREC_LSB +: 3]};
               end
            end
            ST_RUN_P: begin
               if (convDone) begin
                  // background: temperature right after pressure when due
                  if ((isBg && wantT && (tPending || tTick)) || (!isBg && wantT)) begin
                     state <= ST_RUN_T;
                     convReq <= '{1'b1, 1'b0, tmpCfg[pmf_pkg::PREC_LSB +: 3]};
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RUN_T: begin
               if (convDone) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // dedicated result registers when the fifo is off
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         resP <= 24'h000000;
         resT <= 24'h000000;
      end else if (convDone && !fifoEn) begin
         if (state == ST_RUN_P) begin
            resP <= newRes.value;
         end else if (state == ST_RUN_T) begin
            resT <= newRes.value;
         end
      end
   end

   // result fifo, fed in command and background modes alike
   pmf_fifo #(
      .DEPTH(pmf_pkg::FIFO_DEPTH),
      .W(25)
   ) uFifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .push(pushFifo),
      .pushData(newRes),
      .pop(popFifo),
      .stopOnFull(cfg[pmf_pkg::STOP_FULL_BIT]),
      .head(fifoHead),
      .count(fifoCount)
   );

   // new-result flag: a result landing with the read wins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         newFlag <= 1'b0;
      end else if (convDone && state != ST_IDLE) begin
         newFlag <= 1'b1;
      end else if (rdEn && (paddr == pmf_pkg::ADDR_RES_P || paddr == pmf_pkg::ADDR_RES_T)) begin
         newFlag <= 1'b0;
      end
   end

   // interrupt source select
   always_comb begin
      case (cfg[pmf_pkg::INTSEL_LSB +: 4])
         pmf_pkg::INT_NEW: next_int = newFlag;
         pmf_pkg::INT_WM: next_int = wmHit;
         pmf_pkg::INT_FULL: next_int = fifoFull;
         default: next_int = 1'b0; // none
      endcase
   end

   // registered interrupt pin
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         intOut <= 1'b0;
      end else begin
         intOut <= next_int;
      end
   end
endmodule : pmf_top

// *** tb/pmf_top_chk.sv ***
// pmf_top_chk: port assertions of the sequencer
// assumes: bound to pmf_top; one clock, async active-low reset
`timescale 1ns/1ns
module pmf_top_chk (
   input wire logic ref_clk, // clock
   input wire logic rstn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire pmf_pkg::pmf_conv_req_s convReq, // converter request
   input wire logic convDone // converter done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic modeSeen; // a mode write has landed
   logic convBusy; // a conversion is outstanding
   wire logic badA = paddr > 8'h18 || paddr[1:0] != 2'h0; // unmapped address
   // first mode write seen
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) modeSeen <= 1'b0;
      else if (psel && penable && pready && pwrite && paddr == 8'h08) modeSeen <= 1'b1;
   end
   // track start to done
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) convBusy <= 1'b0;
      else if (convReq.start) convBusy <= 1'b1;
      else if (convDone) convBusy <= 1'b0;
   end
   sequence s_setup; psel && !penable; endsequence
   property p_rdy; s_setup |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready missing after setup");
   property p_rdy_acc; pready |-> psel && penable ##1 !pready; endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
   property p_err; s_setup ##0 badA |=> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_noerr; s_setup ##0 !badA |=> !pslverr; endproperty
   a_noerr: assert property (p_noerr) else $error("mapped access refused");
   property p_idle; convReq.start |-> modeSeen; endproperty
   a_idle: assert property (p_idle) else $error("conversion before any mode");
   property p_pulse; convReq.start |=> !convReq.start; endproperty
   a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
   property p_one; convReq.start |-> !convBusy; endproperty
   a_one: assert property (p_one) else $error("start while converting");
   property p_hold; !convReq.start |-> $stable(convReq.isPressure) && $stable(convReq.precision);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed without start");
   property p_empty_err; pready && pslverr |-> !$past(pwrite) || prdata == 32'h0; endproperty
   a_empty_err: assert property (p_empty_err) else $error("error with data");
endmodule : pmf_top_chk

// *** tb/pmf_conv_model.sv ***
// pmf_conv_model: behavioural converter answering start pulses
// assumes: one conversion at a time
`timescale 1ns/1ns
module pmf_conv_model (
   input wire logic ref_clk, // clock
   input wire logic rstn, // reset, active low
   input wire pmf_pkg::pmf_conv_req_s convReq, // request
   input wire logic [7:0] delay, // latency in cycles
   output logic convDone, // one-cycle done
   output logic [23:0] convData // result
);
   logic busy; // conversion running
   logic [7:0] cnt; // cycles left
   logic [7:0] seq; // conversions started
   // count down, then answer
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         seq <= 8'h00;
         convDone <= 1'b0;
         convData <= 24'h0;
      end else begin
         convDone <= 1'b0;
         convData <= ~convData; // not valid outside done
         if (convReq.start) begin
            busy <= 1'b1;
            cnt <= delay;
            seq <= seq + 8'h01;
         end else if (busy && cnt == 8'h00) begin
            busy <= 1'b0;
            convDone <= 1'b1;
            convData <= {7'h55, convReq.isPressure, seq - 8'h01, 8'hff};
         end else if (busy) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : pmf_conv_model

// *** tb/pmf_top_bench.sv ***
// pmf_top_bench: self-checking bench of the measurement sequencer
// assumes: apb master here, converter model on the far side
`timescale 1ns/1ns
module pmf_top_bench;
   typedef struct packed {logic [2:0] m; logic [7:0] a; logic p; logic [7:0] b;} pmf_row_s;
   logic ref_clk = 1'b0; // clock
   logic rstn = 1'b0; // reset, active low
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
   logic [7:0] paddr = 8'h00; // apb address
   logic [31:0] pwdata = 32'h0, prdata, r; // apb data, last read
   logic pready, pslverr, convDone, intOut, e; // outputs, last error
   logic [23:0] convData; // converter result
   pmf_pkg::pmf_conv_req_s convReq; // converter request
   logic [7:0] convDelay = 8'h02, seq = 8'h00; // latency, starts seen
   logic bgOn = 1'b0, lastDoneP = 1'b0; // bg checks
   int errors = 0, n_compared = 0, nP = 0, nT = 0, bad = 0, s;
   logic [23:0] q[$]; // expected fifo
   // command rows: mode, result address, type, starts back
   pmf_row_s rows[4] = '{'{3'h1, 8'h10, 1'b1, 8'h1}, '{3'h2, 8'h14, 1'b0, 8'h1},
                         '{3'h3, 8'h10, 1'b1, 8'h2}, '{3'h3, 8'h14, 1'b0, 8'h1}};
   always #5 ref_clk = ~ref_clk;
   pmf_top #(.RATE_BASE_CYC(1000)) i_pmf_top (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .convReq(convReq), .convDone(convDone),
      .convData(convData), .intOut(intOut));
   pmf_conv_model i_pmf_conv_model (.ref_clk(ref_clk), .rstn(rstn), .convReq(convReq),
      .delay(convDelay), .convDone(convDone), .convData(convData));
   // watch converter starts
   always @(posedge ref_clk) begin
      if (convReq.start === 1'b1) begin
         seq <= seq + 8'h01;
         if (convReq.isPressure) nP++;
         else nT++;
         if (bgOn && convReq.precision !== (convReq.isPressure ? 3'h5 : 3'h2)) bad++;
         if (bgOn && !convReq.isPressure && !lastDoneP) bad++;
      end
      lastDoneP <= convDone & convReq.isPressure;
   end
   function automatic logic [23:0] val(input logic p, input logic [7:0] n);
      return {7'h55, p, n, 7'h7f, p};
   endfunction : val
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk({31'h0, pready}, 32'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // write a mode, poll until standby
   task conv(input logic [2:0] m);
      apb(1'b1, 8'h08, {29'h0, m});
      repeat (80) begin
         apb(1'b0, 8'h08);
         if (r === 32'h0) break;
      end
      chk(r, 32'h0);
      repeat (2) @(posedge ref_clk);
   endtask : conv
   // 34 single shots, then drain
   task fifo_run(input logic stop);
      apb(1'b1, 8'h0c, stop ? 32'h0534 : 32'h0018);
      q.delete();
      for (int i = 0; i < 34; i++) begin
         conv(i[0] ? 3'h2 : 3'h1);
         if (q.size() == 32 && !stop) void'(q.pop_front());
         if (q.size() < 32) q.push_back(val(!i[0], seq - 8'h01));
         if (stop && i == 4) chk({31'h0, intOut}, 32'h1);
         if (stop && i == 5) chk({31'h0, intOut}, 32'h0);
      end
      if (!stop) chk({31'h0, intOut}, 32'h1);
      apb(1'b0, 8'h18);
      chk(r, 32'h2006);
      while (q.size() > 0) begin
         apb(1'b0, 8'h10);
         chk(r, {8'h00, q.pop_front()});
      end
      apb(1'b0, 8'h10);
      chk(r, 32'h800000);
      apb(1'b0, 8'h18);
      chk(r, 32'h1);
      $display("fifo test done, stop %0d", stop);
   endtask : fifo_run
   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   // watchdog
   initial begin
      #600000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      apb(1'b0, 8'h08);
      chk(r, 32'h0);
      apb(1'b0, 8'h18);
      chk(r, 32'h1);
      apb(1'b1, 8'h00, 32'h35);
      apb(1'b1, 8'h04, 32'h22);
      apb(1'b0, 8'h00);
      chk(r, 32'h35);
      apb(1'b0, 8'h04);
      chk(r, 32'h22);
      apb(1'b0, 8'h1c);
      chk({r[30:0], e}, 32'h1);
      $display("register test done");
      foreach (rows[k]) begin
         conv(rows[k].m);
         apb(1'b0, rows[k].a);
         chk(r, {8'h00, val(rows[k].p, seq - rows[k].b)});
      end
      $display("command test done");
      fifo_run(1'b1);
      fifo_run(1'b0);
      apb(1'b1, 8'h0c, 32'h2);
      nP = 0;
      nT = 0;
      bgOn <= 1'b1;
      apb(1'b1, 8'h08, 32'h7);
      repeat (2000) @(posedge ref_clk);
      chk({31'h0, nP >= 15 && nP <= 18 && nT >= 7 && nT <= 10}, 32'h1);
      chk(bad, 0);
      chk({31'h0, intOut}, 32'h1);
      convDelay <= 8'd40;
      repeat (300) begin
         @(posedge ref_clk);
         if (convReq.start === 1'b1) break;
      end
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b0, 8'h08);
      chk(r, 32'hc0);
      conv(3'h0);
      s = nP + nT;
      repeat (600) @(posedge ref_clk);
      chk(nP + nT, s);
      $display("background test done");
      test_done();
   end
endmodule : pmf_top_bench
bind pmf_top pmf_top_chk i_pmf_top_chk (.ref_clk(ref_clk),
   .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .convReq(convReq),
   .convDone(convDone));
